//--- splc_checker.sv
// splc_checker.sv: port assertions of the power and lock control
// assumes bind onto splc_power_lock
`timescale 1ns/1ps
module splc_checker (
    input wire clk, arst_n, clk_en, power_down_n, input_buffer_supply, pll_run_ff, term_en_ff,
    input wire out_drive_en_ff, out_hold_zero_ff, locked_ff, input_capture_en_ff,
    input wire [1:0] freq_range_ff,
    input wire [3:0] band_sel_ff
);
    reg [15:0] cnt_ff;
    always @(posedge clk) cnt_ff <= out_hold_zero_ff ? cnt_ff + {15'h0, clk_en} : 16'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_band_ok: assert property ($stable(freq_range_ff) |-> band_sel_ff == 4'h1 << freq_range_ff)
        else $error("band");
    a_pd_quiet: assert property ((clk_en && !power_down_n)[*4] |-> !pll_run_ff && !term_en_ff)
        else $error("pd");
    a_no_supply: assert property ((clk_en && !input_buffer_supply)[*4] |-> {pll_run_ff, freq_range_ff} == 3'h0)
        else $error("supply");
    a_lock_entry: assert property ($rose(pll_run_ff) |-> term_en_ff && out_hold_zero_ff && !locked_ff)
        else $error("entry");
    a_drive_gate: assert property (out_drive_en_ff |-> locked_ff && !out_hold_zero_ff)
        else $error("drive");
    a_lock_len: assert property ($fell(out_hold_zero_ff) && locked_ff |-> cnt_ff == 16'h4001)
        else $error("len");
    a_pd_clear: assert property (!pll_run_ff |-> !locked_ff && !out_drive_en_ff)
        else $error("clear");
    a_cap_run: assert property (input_capture_en_ff |-> pll_run_ff)
        else $error("cap");
    c_lock: cover property ($rose(locked_ff));
    c_abort: cover property ($fell(out_hold_zero_ff) && !locked_ff);
    c_band: cover property (band_sel_ff == 4'h8);
endmodule // splc_checker
bind splc_power_lock splc_checker i_chk (.*);

//--- splc_host_model.sv
// splc_host_model.sv: host holding the control pins
// assumes the bench hands it pin levels on cmd
`timescale 1ns/1ps
module splc_host_model (
    input wire clk,
    input wire [3:0] cmd,
    output reg [3:0] pins
);
    initial pins = 4'h0;
    always @(negedge clk) pins <= cmd;
endmodule // splc_host_model

//--- splc_power_lock.v
// splc_power_lock.v: power state, range decode and lock sequencing of the serial transmitter
// assumes clk is the parallel clock from the host; pins arrive asynchronously
//
// How it works
// RL1: range select picks one of four clock bands
// RL2: host supplies in-band parallel clock
// RL3: power-down halts multiplier, termination off, output floats
// RL4: release starts lock, reconnects termination
// RL5: no data until lock; output held zero
// RL6: lock lasts 16385 parallel clock cycles
// RL7: missing input supply forces power-down, ignores inputs
// RL8: host keeps power and clock stable
// RL9: parallel clock captures inputs, references multiplier
// RL10: unconnected range and power-down read low
// RL11: power-down clears lock counter
`timescale 1ns/1ps
`include "splc_regs.vh"
module splc_power_lock (
    input wire clk,
    input wire arst_n,
    input wire clk_en,
    input wire power_down_n,
    input wire freq_range_sel_lo,
    input wire freq_range_sel_hi,
    input wire input_buffer_supply,
    output reg pll_run_ff,
    output reg term_en_ff,
    output reg out_drive_en_ff,
    output reg out_hold_zero_ff,
    output reg locked_ff,
    output reg input_capture_en_ff,
    output reg [1:0] freq_range_ff,
    output reg [`SPLC_BAND_W-1:0] band_sel_ff
);
    localparam ST_DOWN = 3'b001;
    localparam ST_LOCK = 3'b010;
    localparam ST_RUN = 3'b100;

    reg rst_meta_ff;
    reg rst_sync_ff;
    wire rst_n = rst_sync_ff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire pd_n_s;
    wire rng_lo_s;
    wire rng_hi_s;
    wire supply_s;
    // all pins sampled on the parallel clock RL9
    splc_sync2 #(
        .RST_VAL(1'b0)
    ) u_pd (
        .clk(clk),
        .arst_n(rst_n),
        .ce(clk_en),
        .d(power_down_n),
        .q(pd_n_s)
    );
    splc_sync2 #(
        .RST_VAL(1'b0)
    ) u_rlo (
        .clk(clk),
        .arst_n(rst_n),
        .ce(clk_en),
        .d(freq_range_sel_lo),
        .q(rng_lo_s)
    );
    splc_sync2 #(
        .RST_VAL(1'b0)
    ) u_rhi (
        .clk(clk),
        .arst_n(rst_n),
        .ce(clk_en),
        .d(freq_range_sel_hi),
        .q(rng_hi_s)
    );
    // supply reset low, so power-down stays forced until the supply is seen
    splc_sync2 #(
        .RST_VAL(1'b0)
    ) u_sup (
        .clk(clk),
        .arst_n(rst_n),
        .ce(clk_en),
        .d(input_buffer_supply),
        .q(supply_s)
    );

    // without the input supply every pin is ignored and power-down forced RL7
    wire pd_eff_n = supply_s & pd_n_s;
    // pins reset and default low, so floating inputs mean power-down, lowest band RL10
    wire [1:0] rng_eff = supply_s ? {rng_hi_s, rng_lo_s} : `SPLC_RNG_3_5;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [`SPLC_CNT_W-1:0] cnt_ff;
    reg [`SPLC_CNT_W-1:0] nxt_cnt;
    reg [`SPLC_BAND_W-1:0] nxt_band;

    always @* begin
        case (rng_eff) // RL1
            `SPLC_RNG_3_5: nxt_band = `SPLC_BAND_3_5;
            `SPLC_RNG_5_10: nxt_band = `SPLC_BAND_5_10;
            `SPLC_RNG_10_20: nxt_band = `SPLC_BAND_10_20;
            `SPLC_RNG_20_35: nxt_band = `SPLC_BAND_20_35;
            default: nxt_band = `SPLC_BAND_3_5;
        endcase
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_DOWN: begin
                nxt_cnt = {`SPLC_CNT_W{1'b0}}; // RL11
                if (pd_eff_n) begin
                    nxt_state = ST_LOCK; // RL4
                end
            end
            ST_LOCK: begin
                if (!pd_eff_n) begin
                    nxt_state = ST_DOWN;
                    nxt_cnt = {`SPLC_CNT_W{1'b0}}; // RL11
                end else if (cnt_ff == `SPLC_LOCK_LAST) begin
                    nxt_state = ST_RUN; // RL6
                    nxt_cnt = {`SPLC_CNT_W{1'b0}};
                end else begin
                    nxt_cnt = cnt_ff + 1'b1; // RL6
                end
            end
            ST_RUN: begin
                if (!pd_eff_n) begin
                    nxt_state = ST_DOWN; // RL3
                end
            end
            default: begin
                nxt_state = ST_DOWN;
                nxt_cnt = {`SPLC_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_DOWN;
            cnt_ff <= {`SPLC_CNT_W{1'b0}};
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // state outputs follow the next state so they change in the same cycle as it; range and band outputs follow rng_eff
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_run_ff <= 1'b0;
        end else if (clk_en) begin
            pll_run_ff <= (nxt_state != ST_DOWN); // RL3
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            term_en_ff <= 1'b0;
        end else if (clk_en) begin
            term_en_ff <= (nxt_state != ST_DOWN); // RL4
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_drive_en_ff <= 1'b0;
        end else if (clk_en) begin
            out_drive_en_ff <= (nxt_state == ST_RUN); // RL5
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_hold_zero_ff <= 1'b0;
        end else if (clk_en) begin
            out_hold_zero_ff <= (nxt_state == ST_LOCK); // RL5
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_ff <= 1'b0;
        end else if (clk_en) begin
            locked_ff <= (nxt_state == ST_RUN); // RL6
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_capture_en_ff <= 1'b0;
        end else if (clk_en) begin
            input_capture_en_ff <= (nxt_state == ST_RUN) & supply_s; // RL9
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_range_ff <= `SPLC_RNG_3_5;
        end else if (clk_en) begin
            freq_range_ff <= rng_eff; // RL1
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            band_sel_ff <= `SPLC_BAND_3_5;
        end else if (clk_en) begin
            band_sel_ff <= nxt_band; // RL1
        end
    end
endmodule // splc_power_lock

//--- splc_regs.vh
// splc_regs.vh: timing counts and encodings for the serializer power/lock control
// assumes inclusion by bare name from the design files
`ifndef SPLC_REGS_VH
`define SPLC_REGS_VH
`define SPLC_LOCK_CYCLES 15'd16385
`define SPLC_LOCK_LAST 15'd16384
`define SPLC_CNT_W 15
`define SPLC_RNG_3_5 2'h0
`define SPLC_RNG_5_10 2'h1
`define SPLC_RNG_10_20 2'h2
`define SPLC_RNG_20_35 2'h3
`define SPLC_BAND_W 4
`define SPLC_BAND_3_5 4'h1
`define SPLC_BAND_5_10 4'h2
`define SPLC_BAND_10_20 4'h4
`define SPLC_BAND_20_35 4'h8
`endif

//--- splc_sync2.v
// splc_sync2.v: two-flop synchroniser for one asynchronous level
// assumes clk is the parallel clock; reset value is a constant parameter
`timescale 1ns/1ps
module splc_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire d,
    output wire q
);
    reg meta_ff;
    reg q_ff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else if (ce) begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule // splc_sync2

//--- test_serializer_power_lock_control.sv
// test_serializer_power_lock_control.sv: scoreboard bench of the power and lock control
// assumes the host model moves the pins at the falling edge
`timescale 1ns/1ps
module test_serializer_power_lock_control;
    reg clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
    reg [3:0] cmd = 4'h8;
    reg [1:0] r = 2'h0;
    reg [31:0] rs = 32'h0000000A;
    reg [11:0] q[$];
    reg [11:0] st_q = 12'h001;
    integer err_total = 0, n_tests = 0, k;
    wire input_buffer_supply, power_down_n, freq_range_sel_hi, freq_range_sel_lo, pll_run_ff, term_en_ff;
    wire out_drive_en_ff, out_hold_zero_ff, locked_ff, input_capture_en_ff;
    wire [1:0] freq_range_ff;
    wire [3:0] band_sel_ff;
    wire [11:0] st = {pll_run_ff, term_en_ff, out_drive_en_ff, out_hold_zero_ff, locked_ff, input_capture_en_ff,
        freq_range_ff, band_sel_ff};
    always #2.5 clk = ~clk;
    splc_host_model i_host (.clk(clk), .cmd(cmd),
        .pins({input_buffer_supply, power_down_n, freq_range_sel_hi, freq_range_sel_lo}));
    splc_power_lock i_dut (.*);
    function [31:0] xs(input [31:0] v);
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [11:0] ex(input [1:0] m, input [1:0] v);
        ex = {{2{m != 2'h0}}, m == 2'h2, m == 2'h1, {2{m == 2'h2}}, v, 4'h1 << v};
    endfunction
    task cmp(input [11:0] e, input [11:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("CHECK FAILED status expected %h seen %h", e, g);
        end
    endtask
    task go(input [3:0] c, input [1:0] m1, input [1:0] m2, input integer w);
        @(posedge clk) cmd <= c;
        q.push_back(ex(m1, c[3] ? c[1:0] : 2'h0));
        if (m2 != m1) q.push_back(ex(m2, c[1:0]));
        repeat (w) @(posedge clk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(negedge clk) begin
        if (arst_n && st !== st_q) cmp(q.size() > 0 ? q.pop_front() : 12'hFFF, st);
        st_q <= st;
    end
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        for (k = 0; k < 8; k = k + 1) begin
            rs = xs(rs);
            r = k < 4 ? k[1:0] ^ 2'h1 : rs[1:0];
            if (r !== cmd[1:0]) go({2'h2, r}, 2'h0, 2'h0, 6);
        end
        $display("range test done");
        @(negedge clk) clk_en = 1'b0;
        go({2'h2, ~r}, 2'h0, 2'h0, 10);
        cmp(ex(2'h0, r), st);
        @(negedge clk) clk_en = 1'b1;
        r = ~r;
        repeat (6) @(negedge clk);
        $display("freeze test done");
        go({2'h3, r}, 2'h1, 2'h2, 16400);
        go({2'h2, r}, 2'h0, 2'h0, 8);
        go({2'h3, r}, 2'h1, 2'h1, 99);
        go({2'h2, r}, 2'h0, 2'h0, 8);
        go({2'h3, r}, 2'h1, 2'h2, 16400);
        $display("lock test done");
        go({2'h1, r}, 2'h0, 2'h0, 8);
        go({2'h3, r}, 2'h1, 2'h2, 16400);
        $display("supply test done");
        cmp(12'h0, 12'(q.size()));
        complete_run;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total = err_total + 1;
        complete_run;
    end
endmodule // test_serializer_power_lock_control
